// >>> verilog/supply_monitor_map.svh
// Offsets, field positions, reset values and counts of the supply monitor
// Assumes APB byte addressing with one 32-bit word per register
`ifndef SUPPLY_MONITOR_MAP_SVH
`define SUPPLY_MONITOR_MAP_SVH

`define SM_ADDR_CLK      8'h00
`define SM_ADDR_CTL      8'h04
`define SM_ADDR_INTF     8'h08
`define SM_ADDR_INTE     8'h0C
`define SM_ADDR_PROT     8'h10

`define SM_CLK_DBRUN     8
`define SM_CLK_DIV_LSB   4
`define SM_CLK_SRC_LSB   0
`define SM_CTL_SRC       15
`define SM_CTL_CNT_LSB   13
`define SM_CTL_THR_LSB   8
`define SM_CTL_RSEL_LSB  4
`define SM_CTL_MODE_LSB  1
`define SM_CTL_EN        0
`define SM_INTF_RESULT   8
`define SM_INTF_FLAG     0
`define SM_INTE_IE       0

`define SM_CLK_DBRUN_RST 1'b1
`define SM_CLK_DIV_RST   3'h0
`define SM_CLK_SRC_RST   2'h0
`define SM_CTL_SRC_RST   1'b0
`define SM_CTL_CNT_RST   2'h0
`define SM_CTL_THR_RST   5'h1E
`define SM_CTL_RSEL_RST  4'h0
`define SM_CTL_MODE_RST  2'h0
`define SM_PROT_RST      16'h0000

`define SM_PROT_UNLOCK   16'h0096
`define SM_RESET_KEY     4'hA
`define SM_MODE_CONT     2'h0
`define SM_DIV_BASE      8'h04
`define SM_DIV_MAX_CODE  3'h5
`define SM_IVL_BASE      10'h080

`endif

// >>> verilog/supply_monitor_pkg.sv
// Types shared by the supply monitor control logic
// Assumes field widths match the constants header
package supply_monitor_pkg;

  typedef struct packed {
    logic       source_sel;
    logic [1:0] count_sel;
    logic [4:0] threshold;
    logic [3:0] reset_sel;
    logic [1:0] mode;
    logic       enable;
  } ctl_t;

  typedef struct packed {
    logic       dbrun;
    logic [2:0] div;
    logic [1:0] src;
  } clk_t;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_CONT,
    ST_SLEEP,
    ST_SENSE
  } mon_state_t;

endpackage : supply_monitor_pkg

// >>> verilog/tick_divider.sv
// Divides a stream of enable ticks by limit+1, one registered pulse out
// Assumes limit is stable while counting; clear restarts the count
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         clear,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] limit,
  output logic              tick_out
);

  logic [W-1:0] cnt_r;

  if (W < 1 || W > 16) begin : g_bad_width
    $error("tick_divider width out of range");
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r    <= '0;
      tick_out <= 1'b0;
    end else if (ce) begin
      tick_out <= 1'b0;
      if (clear) begin
        cnt_r <= '0;
      end else if (tick_in) begin
        if (cnt_r >= limit) begin
          cnt_r    <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_r <= W'(cnt_r + 1'b1);
        end
      end
    end
  end

endmodule : tick_divider
`default_nettype wire

// >>> verilog/low_run_counter.sv
// Counts consecutive low detections, flags the one that reaches need
// Assumes hit and miss never both high; restarts after reaching
`timescale 1ns/10ps
`default_nettype none
module low_run_counter #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         clear,
  input  wire logic         hit,
  input  wire logic         miss,
  input  wire logic [W-1:0] need,
  output logic              reached
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_inc;

  if (W < 2 || W > 8) begin : g_bad_width
    $error("low_run_counter width out of range");
  end

  assign cnt_inc = W'(cnt_r + 1'b1);
  assign reached = hit & ~clear & (cnt_inc == need);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (clear || miss || reached) begin
        cnt_r <= '0;
      end else if (hit) begin
        cnt_r <= cnt_inc;
      end
    end
  end

endmodule : low_run_counter
`default_nettype wire

// >>> verilog/supply_monitor_control.sv
// Supply monitor control: APB registers, comparator sequencing, events
// Assumes src_tick carries one pulse per source clock cycle, synchronous
// to clk, and comp_below is the settled comparator output
//
// Notes on behaviour
// (RQ1) Software unlocks with key 0x0096, clears enable, then relocks.
// (RQ2) Result bit reads 1 when supply is below threshold, else 0.
// (RQ3) Software waits the enable response time before trusting result.
// (RQ4) After a threshold change software waits the response time.
// (RQ5) Mode 0 samples continuously while enabled, updating result.
// (RQ6) Continuous low result issues reset if select is 0xA, else flag.
// (RQ7) Modes 1 to 3 power comparator per interval, sample, power off.
// (RQ8) Intermittent events need the configured consecutive low count.
// (RQ9) Interrupt request only while flag set and enable bit is 1.
// (RQ10) Flag stays set on recovery; cleared only by writing 1.
// (RQ11) Reset asserts exactly when the flag would be set.
// (RQ12) After issuing reset the block runs continuously and monitors.
// (RQ13) External sense routing survives the monitor-issued reset.
// (RQ14) Supply recovery drives result 0 and releases the reset.
// (RQ15) Reset state clears mode, count and irq enable, keeps the rest.
// (RQ16) Reset state returns clock control fields to initial values.
// (RQ17) Clock control: debug-run bit 8, divider 6-4, source 1-0.
// (RQ18) Debug-run 1 keeps monitor clock and operation in debug.
// (RQ19) Debug-run 0 stops monitor clock in debug, state retained.
// (RQ20) Interval is monitor clock over 128, 256 or 512 for modes 1-3.
// (RQ21) Count select 0 to 3 needs 1, 2, 4 or 8 low detections.
// (RQ22) Run count clears on a good sample and on disable.
// (RQ23) Protected fields change only while protection is unlocked.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "supply_monitor_map.svh"
module supply_monitor_control #(
  parameter int SETTLE_TICKS = 2
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  src_tick,
  input  wire logic        debug_mode,
  input  wire logic        comp_below,
  output logic             comp_power_en,
  output logic             comp_source_sel,
  output logic      [4:0]  comp_threshold,
  output logic             monitor_reset_req,
  output logic             low_voltage_irq
);

  if (SETTLE_TICKS < 1 || SETTLE_TICKS > 15) begin : g_bad_settle
    $error("SETTLE_TICKS must lie in 1..15");
  end

  localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_TICKS - 1);

  supply_monitor_pkg::ctl_t       ctl_r;
  supply_monitor_pkg::clk_t       clk_r;
  supply_monitor_pkg::mon_state_t st_r;
  logic        flag_r;
  logic        irq_en_r;
  logic [15:0] key_r;
  logic        result_r;
  logic        rst_state_r;
  logic [3:0]  settle_r;
  logic        ph_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  logic        acc;
  logic        wr;
  logic        unlocked;
  logic        mapped;
  logic [31:0] rd_data;
  logic        wr_ctl;
  logic        flag_clr;
  logic        cfg_change;
  logic        init;
  logic        en;
  logic        cont_mode;
  logic        sel_tick;
  logic        tick_run;
  logic [6:0]  div_lim;
  logic [8:0]  ivl_lim;
  logic        mon_tick;
  logic        ivl_tick;
  logic        sense_done;
  logic        sample;
  logic        cont_event;
  logic        run_reached;
  logic        lv_event;
  logic        issue_rst;
  logic [3:0]  need;

  // APB slave, one access cycle once the read word is captured
  assign acc      = ce & psel & penable & ph_r;
  assign wr       = acc & pwrite & mapped;
  assign pready   = acc;
  assign prdata   = prdata_r;
  assign pslverr  = pslverr_r;
  // (RQ23) key comparison
  assign unlocked = (key_r == `SM_PROT_UNLOCK);

  always_comb begin
    rd_data = 32'h0000_0000;
    mapped  = 1'b1;
    unique case (paddr)
      `SM_ADDR_CLK: begin
        // (RQ17) clock control layout
        rd_data[`SM_CLK_DBRUN]        = clk_r.dbrun;
        rd_data[`SM_CLK_DIV_LSB +: 3] = clk_r.div;
        rd_data[`SM_CLK_SRC_LSB +: 2] = clk_r.src;
      end
      `SM_ADDR_CTL: begin
        rd_data[`SM_CTL_SRC]           = ctl_r.source_sel;
        rd_data[`SM_CTL_CNT_LSB +: 2]  = ctl_r.count_sel;
        rd_data[`SM_CTL_THR_LSB +: 5]  = ctl_r.threshold;
        rd_data[`SM_CTL_RSEL_LSB +: 4] = ctl_r.reset_sel;
        rd_data[`SM_CTL_MODE_LSB +: 2] = ctl_r.mode;
        rd_data[`SM_CTL_EN]            = ctl_r.enable;
      end
      `SM_ADDR_INTF: begin
        // (RQ2) live result bit
        rd_data[`SM_INTF_RESULT] = result_r;
        rd_data[`SM_INTF_FLAG]   = flag_r;
      end
      `SM_ADDR_INTE: begin
        rd_data[`SM_INTE_IE] = irq_en_r;
      end
      `SM_ADDR_PROT: begin
        rd_data[15:0] = key_r;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Read word captured before pready so prdata comes from a flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_r      <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      if (acc) begin
        ph_r <= 1'b0;
      end else if (psel) begin
        ph_r      <= 1'b1;
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_r <= ~mapped;
      end
    end
  end

  assign wr_ctl   = wr & (paddr == `SM_ADDR_CTL) & unlocked & ~rst_state_r;
  assign flag_clr = wr & (paddr == `SM_ADDR_INTF) & pwdata[`SM_INTF_FLAG];
  assign cfg_change = wr_ctl &
    ((pwdata[`SM_CTL_RSEL_LSB +: 4] != ctl_r.reset_sel) ||
     (pwdata[`SM_CTL_MODE_LSB +: 2] != ctl_r.mode) ||
     ((ctl_r.mode != `SM_MODE_CONT) &&
      (pwdata[`SM_CTL_CNT_LSB +: 2] != ctl_r.count_sel)));
  // Restart sequencing on a live mode, count or reset select change, or flag clear
  assign init      = ctl_r.enable & (cfg_change | flag_clr);
  assign en        = ctl_r.enable;
  assign cont_mode = (ctl_r.mode == `SM_MODE_CONT) | rst_state_r;

  // Protection key itself is always writable
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      key_r <= `SM_PROT_RST;
    end else if (ce && wr && paddr == `SM_ADDR_PROT) begin
      key_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r.source_sel <= `SM_CTL_SRC_RST;
      ctl_r.count_sel  <= `SM_CTL_CNT_RST;
      ctl_r.threshold  <= `SM_CTL_THR_RST;
      ctl_r.reset_sel  <= `SM_CTL_RSEL_RST;
      ctl_r.mode       <= `SM_CTL_MODE_RST;
      ctl_r.enable     <= 1'b0;
    end else if (ce) begin
      if (rst_state_r) begin
        // (RQ15) clear mode and count only
        ctl_r.mode      <= `SM_MODE_CONT;
        ctl_r.count_sel <= `SM_CTL_CNT_RST;
      end else if (wr_ctl) begin
        // (RQ23) protected configuration write
        ctl_r.source_sel <= pwdata[`SM_CTL_SRC];
        ctl_r.threshold  <= pwdata[`SM_CTL_THR_LSB +: 5];
        ctl_r.reset_sel  <= pwdata[`SM_CTL_RSEL_LSB +: 4];
        ctl_r.mode       <= pwdata[`SM_CTL_MODE_LSB +: 2];
        ctl_r.enable     <= pwdata[`SM_CTL_EN];
        // Count select ignored while in continuous mode
        if (ctl_r.mode != `SM_MODE_CONT) begin
          ctl_r.count_sel <= pwdata[`SM_CTL_CNT_LSB +: 2];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_r.dbrun <= `SM_CLK_DBRUN_RST;
      clk_r.div   <= `SM_CLK_DIV_RST;
      clk_r.src   <= `SM_CLK_SRC_RST;
    end else if (ce) begin
      if (rst_state_r) begin
        // (RQ16) clock fields to initial
        clk_r.dbrun <= `SM_CLK_DBRUN_RST;
        clk_r.div   <= `SM_CLK_DIV_RST;
        clk_r.src   <= `SM_CLK_SRC_RST;
      end else if (wr && paddr == `SM_ADDR_CLK && unlocked) begin
        // (RQ23) protected clock write
        clk_r.dbrun <= pwdata[`SM_CLK_DBRUN];
        clk_r.div   <= pwdata[`SM_CLK_DIV_LSB +: 3];
        clk_r.src   <= pwdata[`SM_CLK_SRC_LSB +: 2];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_en_r <= 1'b0;
    end else if (ce) begin
      if (rst_state_r) begin
        // (RQ15) irq enable cleared
        irq_en_r <= 1'b0;
      end else if (wr && paddr == `SM_ADDR_INTE) begin
        irq_en_r <= pwdata[`SM_INTE_IE];
      end
    end
  end

  // Monitor clock as a tick: source pick, debug gate, divider
  assign sel_tick = src_tick[clk_r.src];
  // (RQ18) (RQ19) debug gating retains all state
  assign tick_run = ~debug_mode | clk_r.dbrun;
  assign div_lim  = (clk_r.div > `SM_DIV_MAX_CODE) ? 7'h00 :
                    7'((`SM_DIV_BASE << clk_r.div) - 8'h01);

  tick_divider #(
    .W (7)
  ) u_mon_div (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .clear    (1'b0),
    .tick_in  (sel_tick & tick_run),
    .limit    (div_lim),
    .tick_out (mon_tick)
  );

  // (RQ20) interval of 128, 256 or 512 monitor ticks
  assign ivl_lim = 9'((`SM_IVL_BASE << (ctl_r.mode - 2'h1)) - 10'h001);

  tick_divider #(
    .W (9)
  ) u_interval (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .clear    (st_r != supply_monitor_pkg::ST_SLEEP || init),
    .tick_in  (mon_tick),
    .limit    (ivl_lim),
    .tick_out (ivl_tick)
  );

  assign sense_done = (st_r == supply_monitor_pkg::ST_SENSE) &&
                      (settle_r == SETTLE_LAST);
  // (RQ5) continuous sampling each monitor tick
  assign sample = en & mon_tick & ~init &
                  ((st_r == supply_monitor_pkg::ST_CONT) | sense_done);

  // (RQ7) power, settle, sample, power off
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r     <= supply_monitor_pkg::ST_OFF;
      settle_r <= 4'h0;
    end else if (ce) begin
      unique case (st_r)
        supply_monitor_pkg::ST_OFF: begin
          if (en) begin
            st_r <= cont_mode ? supply_monitor_pkg::ST_CONT
                              : supply_monitor_pkg::ST_SLEEP;
          end
        end
        supply_monitor_pkg::ST_CONT: begin
          if (!en) begin
            st_r <= supply_monitor_pkg::ST_OFF;
          end else if (!cont_mode) begin
            st_r <= supply_monitor_pkg::ST_SLEEP;
          end
        end
        supply_monitor_pkg::ST_SLEEP: begin
          settle_r <= 4'h0;
          if (!en) begin
            st_r <= supply_monitor_pkg::ST_OFF;
          end else if (cont_mode) begin
            st_r <= supply_monitor_pkg::ST_CONT;
          end else if (ivl_tick && !init) begin
            st_r <= supply_monitor_pkg::ST_SENSE;
          end
        end
        supply_monitor_pkg::ST_SENSE: begin
          if (!en) begin
            st_r <= supply_monitor_pkg::ST_OFF;
          end else if (cont_mode) begin
            st_r <= supply_monitor_pkg::ST_CONT;
          end else if (init || (mon_tick && sense_done)) begin
            st_r <= supply_monitor_pkg::ST_SLEEP;
          end else if (mon_tick) begin
            settle_r <= 4'(settle_r + 4'h1);
          end
        end
      endcase
    end
  end

  // (RQ2) (RQ14) result follows each sample, held when idle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      result_r <= 1'b0;
    end else if (ce && sample) begin
      result_r <= comp_below;
    end
  end

  // (RQ21) need of 1, 2, 4 or 8
  assign need = 4'(5'h01 << ctl_r.count_sel);

  // (RQ8) (RQ22) consecutive low run
  low_run_counter #(
    .W (4)
  ) u_run (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .clear   (~en | init | cont_mode),
    .hit     (sample & ~cont_mode & comp_below),
    .miss    (sample & ~comp_below),
    .need    (need),
    .reached (run_reached)
  );

  // (RQ6) rising low result in continuous mode
  assign cont_event = sample & cont_mode & comp_below & ~result_r;
  assign lv_event   = cont_event | run_reached;
  // (RQ11) reset shares the flag's moment
  assign issue_rst  = lv_event & (ctl_r.reset_sel == `SM_RESET_KEY);

  // (RQ10) set wins over a write-1 clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_r <= 1'b0;
    end else if (ce) begin
      if (lv_event) begin
        flag_r <= 1'b1;
      end else if (flag_clr) begin
        flag_r <= 1'b0;
      end
    end
  end

  // (RQ12) (RQ14) held until a good continuous sample
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_state_r <= 1'b0;
    end else if (ce) begin
      if (issue_rst) begin
        rst_state_r <= 1'b1;
      end else if (rst_state_r && sample && !comp_below) begin
        rst_state_r <= 1'b0;
      end
    end
  end

  assign monitor_reset_req = rst_state_r;
  // (RQ9) flag gated by enable
  assign low_voltage_irq   = flag_r & irq_en_r;
  assign comp_power_en     = (st_r == supply_monitor_pkg::ST_CONT) ||
                             (st_r == supply_monitor_pkg::ST_SENSE);
  // (RQ13) source select kept through reset
  assign comp_source_sel   = ctl_r.source_sel;
  assign comp_threshold    = ctl_r.threshold;

endmodule : supply_monitor_control
`default_nettype wire

// >>> verification/comparator_model.sv
// Comparator model on the sensed supply, far side of the block
// Assumes levels in threshold steps; unpowered output is junk
`timescale 1ns/10ps
`default_nettype none
module comparator_model (
  input  wire logic       clk,
  input  wire logic       power_en,
  input  wire logic       source_sel,
  input  wire logic [4:0] threshold,
  input  wire logic [5:0] level_vdd,
  input  wire logic [5:0] level_ext,
  output logic            below
);
  logic       junk = 1'h0;
  logic [5:0] lvl;
  // Unpowered output must never look valid
  always @(posedge clk) junk <= ~junk;
  assign lvl = source_sel ? level_ext : level_vdd;
  assign below = power_en ? (lvl < {1'h0, threshold}) : junk;
endmodule : comparator_model
`default_nettype wire

// >>> verification/supply_monitor_control_chk.sv
// Port checker of the supply monitor control block
// Assumes one clock domain, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_control_chk (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        comp_below,
  input wire logic        comp_power_en,
  input wire logic        comp_source_sel,
  input wire logic [4:0]  comp_threshold,
  input wire logic        monitor_reset_req,
  input wire logic        low_voltage_irq
);
  logic acc;
  logic wr_ctl;
  logic wr_inte;
  logic held;
  logic req_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  assign acc = psel && penable && pready;
  assign wr_ctl = acc && pwrite && paddr == 8'h04;
  assign wr_inte = acc && pwrite && paddr == 8'h0C;
  assign held = monitor_reset_req && req_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_r <= 1'h0;
    end else begin
      req_r <= monitor_reset_req;
    end
  end
  property p_ready;
    ce && psel && !penable ##1 ce && psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access not ready");
  property p_decode;
    acc |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10});
  endproperty
  a_decode: assert property (p_decode) else $error("bad decode");
  property p_clk_bits;
    acc && !pwrite && paddr == 8'h00 |-> (prdata & 32'hFFFFFE8C) == 32'h0;
  endproperty
  a_clk_bits: assert property (p_clk_bits)
    else $error("clock reg spare bits");
  property p_cfg_write;
    $changed({comp_source_sel, comp_threshold}) |-> $past(wr_ctl);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config moved without write");
  property p_hold;
    held |-> $stable({comp_source_sel, comp_threshold});
  endproperty
  a_hold: assert property (p_hold) else $error("source lost");
  property p_cont;
    held |-> comp_power_en;
  endproperty
  a_cont: assert property (p_cont) else $error("not continuous");
  property p_ie_clr;
    held |-> !low_voltage_irq;
  endproperty
  a_ie_clr: assert property (p_ie_clr) else $error("irq in reset");
  property p_rst_cause;
    $rose(monitor_reset_req) |-> $past(comp_below) || $past(comp_below, 2);
  endproperty
  a_rst_cause: assert property (p_rst_cause)
    else $error("reset without low");
  property p_rst_free;
    $fell(monitor_reset_req) |-> !$past(comp_below) || !$past(comp_below, 2);
  endproperty
  a_rst_free: assert property (p_rst_free)
    else $error("reset freed while low");
  property p_irq_cause;
    $rose(low_voltage_irq) |->
      $past(comp_below) || $past(comp_below, 2) || $past(wr_inte);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq without cause");
  c_reset: cover property ($rose(monitor_reset_req));
  c_irq: cover property ($rose(low_voltage_irq));
  c_err: cover property (acc && pslverr);
endmodule : supply_monitor_control_chk
bind supply_monitor_control supply_monitor_control_chk chk (
  .clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .comp_below, .comp_power_en, .comp_source_sel,
  .comp_threshold, .monitor_reset_req, .low_voltage_irq
);
`default_nettype wire

// >>> verification/supply_monitor_control_tb.sv
// Self-checking bench of the supply monitor control block
// Assumes zero wait APB and the comparator model at the far side
`timescale 1ns/10ps
`default_nettype none
module supply_monitor_control_tb;
  localparam int ST = 2;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic        debug_mode = 1'h0;
  logic        pw_r = 1'h0;
  logic        rq = 1'h0;
  logic        m_flag = 1'h0;
  logic        m_ie = 1'h0;
  logic        er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] m_clk = 32'h100;
  logic [31:0] m_ctl = 32'h1E00;
  logic [31:0] rd;
  logic [31:0] prdata;
  logic [15:0] key = 16'h0;
  logic [3:0]  src_tick = 4'h0;
  logic [5:0]  lvl_vdd = 6'h3F;
  logic [5:0]  lvl_ext = 6'h3F;
  logic [4:0]  comp_threshold;
  logic        pready, pslverr, comp_below, comp_power_en, comp_source_sel;
  logic        monitor_reset_req, low_voltage_irq;
  int          errors = 0, checked = 0, seed = 56, cyc = 0, sel = 0;
  int          rises = 0, spc = 0, sp0 = 0, gap = 0, thr, r0, k;
  int          mt[4] = '{1, 2, 3, 1};
  int          ct[4] = '{3, 1, 2, 0};
  supply_monitor_control #(.SETTLE_TICKS(ST)) dut (
    .clk(clk), .rstn(rstn), .ce(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_tick(src_tick),
    .debug_mode(debug_mode), .comp_below(comp_below),
    .comp_power_en(comp_power_en), .comp_source_sel(comp_source_sel),
    .comp_threshold(comp_threshold), .monitor_reset_req(monitor_reset_req),
    .low_voltage_irq(low_voltage_irq));
  comparator_model cmp (
    .clk(clk), .power_en(comp_power_en), .source_sel(comp_source_sel),
    .threshold(comp_threshold), .level_vdd(lvl_vdd), .level_ext(lvl_ext),
    .below(comp_below));
  always #5 clk = ~clk;
  // Sample spacing measured in source pulses, not clk cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    src_tick <= 4'($random(seed));
    pw_r <= comp_power_en;
    if (src_tick[sel] === 1'h1) spc <= spc + 1;
    if (comp_power_en && !pw_r) begin
      rises <= rises + 1;
      gap <= spc - sp0;
      sp0 <= spc;
    end
    if (cyc == 90000) begin
      errors = errors + 1;
      close_out();
    end
  end
  function automatic logic [31:0] ctl(input int s, c, t, r, m, e);
    ctl = 32'((s << 15) | (c << 13) | (t << 8) | (r << 4) | (m << 1) | e);
  endfunction : ctl
  task automatic close_out;
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    if (a == 8'h10) key = d[15:0];
    if (a == 8'h0C) m_ie = d[0];
    if (a == 8'h08 && d[0]) m_flag = 1'h0;
    if (key == 16'h0096 && a == 8'h00) m_clk = d & 32'h173;
    if (key == 16'h0096 && a == 8'h04 && !rq)
      m_ctl = (d & 32'h9FF7) | ((m_ctl[2:1] != 0 ? d : m_ctl) & 32'h6000);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string n);
    apb(1'h0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdchk
  task automatic regs;
    rdchk(8'h00, m_clk, "clk reg");
    rdchk(8'h04, m_ctl, "ctl reg");
    rdchk(8'h0C, {31'h0, m_ie}, "inte reg");
    apb(1'h0, 8'h08, 32'h0);
    chk("flag", {31'h0, m_flag}, rd & 32'h1);
  endtask : regs
  task automatic wait_on(input bit r, input logic v);
    for (int i = 0; i < 60000; i++) begin
      @(negedge clk);
      if ((r ? monitor_reset_req : low_voltage_irq) === v) break;
    end
  endtask : wait_on
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    sel = $random(seed) & 3;
    thr = ($random(seed) & 15) + 4;
    regs();
    apb(1'h0, 8'h14, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    wr(8'h04, 32'h1);
    wr(8'h10, 32'h96);
    regs();
    debug_mode <= 1'h1;
    wr(8'h00, 32'h100 | ((($random(seed) & 1)) << 4) | sel);
    wr(8'h0C, 32'h1);
    lvl_vdd <= 6'(thr + 3);
    wr(8'h04, ctl(0, 0, thr, 0, 0, 1));
    repeat (800) @(posedge clk);
    rdchk(8'h08, 32'h0, "intf high");
    lvl_vdd <= 6'(thr - 1);
    wait_on(0, 1'h1);
    m_flag = 1'h1;
    rdchk(8'h08, 32'h101, "intf low");
    lvl_vdd <= 6'(thr);
    repeat (800) @(posedge clk);
    rdchk(8'h08, 32'h1, "intf at thr");
    wr(8'h08, 32'h0);
    rdchk(8'h08, 32'h1, "flag kept");
    wr(8'h08, 32'h1);
    chk("irq off", 32'h0, {31'h0, low_voltage_irq});
    wr(8'h00, 32'(sel));
    lvl_vdd <= 6'(thr - 1);
    repeat (800) @(posedge clk);
    rdchk(8'h08, 32'h0, "frozen");
    debug_mode <= 1'h0;
    wait_on(0, 1'h1);
    wr(8'h0C, 32'h0);
    chk("masked", 32'h0, {31'h0, low_voltage_irq});
    wr(8'h0C, 32'h1);
    chk("unmasked", 32'h1, {31'h0, low_voltage_irq});
    wr(8'h00, 32'h100 | sel);
    for (k = 0; k < 4; k++) begin
      wr(8'h04, ctl(0, 0, thr, 0, 0, 0));
      wr(8'h08, 32'h1);
      wr(8'h04, ctl(0, 0, thr, 0, mt[k], 0));
      wr(8'h04, ctl(0, ct[k], thr, 0, mt[k], 1));
      r0 = rises;
      wait_on(0, 1'h1);
      chk("lows", 32'(1 << ct[k]), 32'(rises - r0));
      if (ct[k] != 0)
        chk("gap", 32'(((128 << (mt[k] - 1)) + ST) * 4), 32'(gap));
    end
    wr(8'h04, ctl(0, 0, thr, 0, 0, 0));
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h10 | sel);
    lvl_vdd <= 6'h3F;
    lvl_ext <= 6'(thr - 1);
    wr(8'h04, ctl(1, 0, thr, 10, 1, 0));
    wr(8'h04, ctl(1, 1, thr, 10, 1, 1));
    wait_on(1, 1'h1);
    chk("reset", 32'h1, {31'h0, monitor_reset_req});
    rq = 1'h1;
    m_flag = 1'h1;
    m_ie = 1'h0;
    m_clk = 32'h100;
    m_ctl = ctl(1, 0, thr, 10, 0, 1);
    wr(8'h04, 32'h0);
    regs();
    lvl_ext <= 6'(thr + 2);
    wait_on(1, 1'h0);
    rq = 1'h0;
    rdchk(8'h08, 32'h1, "freed");
    wr(8'h04, ctl(1, 0, thr, 10, 0, 0));
    wr(8'h10, 32'($random(seed)) & 32'h7F00);
    wr(8'h04, ctl(1, 0, thr, 10, 0, 1));
    regs();
    rstn <= 1'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    key = 16'h0;
    m_flag = 1'h0;
    m_clk = 32'h100;
    m_ctl = 32'h1E00;
    regs();
    close_out();
  end
endmodule : supply_monitor_control_tb
`default_nettype wire
